//--- rtl/rvw_initial_reset.sv
// Initial-reset combiner with pin filter, key combination, oscillation detector and watchdog.
//
// Notes on behaviour
// - Low reset pin holds CPU in reset.
// - Reset pin low must last 2 ms.
// - Selected keys low 2 s cause reset.
// - Key choice: off, two, three, four lines.
// - Reset held until low-speed oscillator starts.
// - Unclear watchdog resets CPU after 3-4 s.
// - Watchdog keeps counting during CPU halt.
// - Writing one to clear bit zeroes watchdog.
// - Watchdog clear bit always reads zero.
// - Timer clear write advances watchdog by one.
// - Reset loads step, page, bank, pointers, flags.
//
// The implementer's own choice: the Avalon-MM slave port.
module rvw_initial_reset
  import rvw_pkg::*;
#(
  parameter int PIN_HOLD = PIN_FILTER_CYCLES,
  parameter int KEY_HOLD = KEY_HOLD_CYCLES,
  parameter int OSC_EDGES = OSC_START_EDGES
)(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          ce,
  // Avalon-MM slave.
  input  wire logic   [13:0] avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic   [31:0] avs_writedata,
  input  wire logic    [3:0] avs_byteenable,
  output logic        [31:0] avs_readdata,
  output logic               avs_waitrequest,
  // Pins and neighbouring blocks.
  input  wire logic          reset_n,
  input  wire logic    [3:0] key_input_lines,
  input  wire logic          low_speed_oscillator,
  input  wire logic          clock_timer_tick_1hz,
  output logic               clock_timer_clear,
  output logic               cpu_reset,
  output rvw_cpu_init_s      cpu_init
);

  localparam int PW = $clog2(PIN_HOLD + 1);
  localparam int KW = $clog2(KEY_HOLD + 1);
  localparam int OW = $clog2(OSC_EDGES + 1);

  logic          [5:0] pins_agreed;
  logic                pin_low;
  logic          [3:0] keys;
  logic                osc_level;
  logic                osc_prev;
  logic                osc_tick;
  logic       [PW-1:0] pin_cnt;
  logic       [KW-1:0] key_cnt;
  logic       [OW-1:0] osc_cnt;
  logic                osc_ok;
  logic                pin_reset;
  logic                key_active;
  logic                key_reset;
  rvw_key_sel_e        key_sel;
  logic                wd_fire;
  logic          [1:0] wd_count;
  logic                wd_pending;
  logic                raw_reset;
  logic                bus_req;
  logic                bus_ack;
  logic                hit_clear;
  logic                hit_key;
  logic                hit_status;
  logic                wr_take;
  logic                wd_clear;
  logic                timer_adv;
  logic         [31:0] next_readdata;

  // All outside levels, the oscillator among them, share one synchroniser bank.
  rvw_pin_sync #(
    .W    (6),
    .INIT (6'h1f)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pin     ({low_speed_oscillator, key_input_lines, reset_n}),
    .agreed  (pins_agreed)
  );

  assign pin_low   = !pins_agreed[0];
  assign keys      = pins_agreed[4:1];
  assign osc_level = pins_agreed[5];
  assign osc_tick  = osc_level && !osc_prev;

  // Oscillator edge detection and start-up proof.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      osc_prev <= 1'b0;
      osc_cnt  <= '0;
      osc_ok   <= 1'b0;
    end
    else if (ce)
    begin
      osc_prev <= osc_level;
      if (osc_tick && !osc_ok)
      begin
        osc_cnt <= osc_cnt + OW'(1);
        if (osc_cnt == OW'(OSC_EDGES - 1))
        begin
          osc_ok <= 1'b1;
        end
      end
    end
  end

  // Noise rejector: the pin must stay low for the whole hold time to count.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_cnt <= '0;
    end
    else if (ce)
    begin
      if (!pin_low)
      begin
        pin_cnt <= '0;
      end
      else if (pin_cnt != PW'(PIN_HOLD))
      begin
        pin_cnt <= pin_cnt + PW'(1);
      end
    end
  end

  assign pin_reset = pin_low && (pin_cnt == PW'(PIN_HOLD));

  // Only the chosen key lines take part; all must be low together.
  always_comb
  begin
    case (key_sel)
      RVW_KEY_01:   key_active = (keys[1:0] == 2'h0);
      RVW_KEY_012:  key_active = (keys[2:0] == 3'h0);
      RVW_KEY_0123: key_active = (keys == 4'h0);
      default:      key_active = 1'b0;
    endcase
  end

  // Long-press timer; a single released line restarts the wait.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      key_cnt <= '0;
    end
    else if (ce)
    begin
      if (!key_active)
      begin
        key_cnt <= '0;
      end
      else if (key_cnt != KW'(KEY_HOLD))
      begin
        key_cnt <= key_cnt + KW'(1);
      end
    end
  end

  assign key_reset = key_active && (key_cnt == KW'(KEY_HOLD));

  rvw_watchdog u_wd (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .cpu_reset (cpu_reset),
    .tick_1hz  (clock_timer_tick_1hz),
    .clear     (wd_clear),
    .advance   (timer_adv),
    .fire      (wd_fire),
    .count     (wd_count)
  );

  // A watchdog timeout is a single event, so it is held until an oscillator edge while cpu_reset stands.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wd_pending <= 1'b0;
    end
    else if (ce)
    begin
      if (wd_fire)
      begin
        wd_pending <= 1'b1;
      end
      else if (osc_tick && cpu_reset)
      begin
        wd_pending <= 1'b0;
      end
    end
  end

  // The oscillator detector holds reset from power-on; pin, keys and the watchdog are further sources.
  assign raw_reset = pin_reset || key_reset || !osc_ok || wd_pending;

  // Reset sets at once and releases only on an oscillator edge, aligning the CPU start.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cpu_reset <= 1'b1;
    end
    else if (ce)
    begin
      if (raw_reset)
      begin
        cpu_reset <= 1'b1;
      end
      else if (osc_tick)
      begin
        cpu_reset <= 1'b0;
      end
    end
  end

  // Initial CPU values are loaded while reset stands.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cpu_init <= '0;
    end
    else if (ce && cpu_reset)
    begin
      cpu_init <= {INIT_STEP, INIT_PAGE, INIT_BANK, INIT_NEXT_PAGE, INIT_NEXT_BANK,
                   INIT_INT_FLAG, INIT_DEC_FLAG};
    end
  end

  // Bus slave answers on the second edge of every request.
  assign bus_req         = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !bus_ack;
  assign wr_take         = ce && avs_write && bus_ack && avs_byteenable[0];

  // Misaligned byte addresses select nothing, so they read zero and write nowhere.
  always_comb
  begin
    hit_clear  = 1'b0;
    hit_key    = 1'b0;
    hit_status = 1'b0;
    if (avs_address[1:0] == 2'h0 && avs_address[13:2] == REG_CLEAR_IDX)
    begin
      hit_clear = 1'b1;
    end
    else if (avs_address[1:0] == 2'h0 && avs_address[13:2] == REG_KEY_CFG_IDX)
    begin
      hit_key = 1'b1;
    end
    else if (avs_address[1:0] == 2'h0 && avs_address[13:2] == REG_STATUS_IDX)
    begin
      hit_status = 1'b1;
    end
  end

  // Write-one strobes; a zero in either bit does nothing.
  assign wd_clear  = wr_take && hit_clear && avs_writedata[WD_CLEAR_BIT];
  assign timer_adv = wr_take && hit_clear && avs_writedata[TIMER_CLEAR_BIT];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_ack           <= 1'b0;
      clock_timer_clear <= 1'b0;
    end
    else if (ce)
    begin
      bus_ack           <= bus_req && !bus_ack;
      clock_timer_clear <= timer_adv;
    end
  end

  // Key choice register steers the combination logic.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      key_sel <= KEY_CFG_RESET;
    end
    else if (wr_take && hit_key)
    begin
      key_sel <= rvw_key_sel_e'(avs_writedata[1:0]);
    end
  end

  // Clear bits are write-only and unmapped words read zero.
  always_comb
  begin
    next_readdata = 32'h0;
    if (hit_key)
    begin
      next_readdata[1:0] = key_sel;
    end
    else if (hit_status)
    begin
      next_readdata[STAT_WD_LSB +: 2]  = wd_count;
      next_readdata[STAT_OSC_BIT]      = osc_ok;
      next_readdata[STAT_KEY_LSB +: 4] = keys;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      avs_readdata <= 32'h0;
    end
    else if (ce && avs_read && !bus_ack)
    begin
      avs_readdata <= next_readdata;
    end
  end

  // Checks on the combined reset; a released line must restart its hold counter at once.
  property p_pin_resets;
    @(posedge clk) disable iff (sys_rst) ce && pin_reset |=> cpu_reset;
  endproperty
  a_pin_resets: assert property (p_pin_resets) else $error("pin low did not reset");
  property p_pin_filtered;
    @(posedge clk) disable iff (sys_rst) ce && !pin_low |=> pin_cnt == PW'(0) && !pin_reset;
  endproperty
  a_pin_filtered: assert property (p_pin_filtered) else $error("short pin pulse taken");
  property p_key_hold;
    @(posedge clk) disable iff (sys_rst) ce && !key_active |=> key_cnt == KW'(0) && !key_reset;
  endproperty
  a_key_hold: assert property (p_key_hold) else $error("short key press taken");
  property p_key_off;
    @(posedge clk) disable iff (sys_rst) key_sel == RVW_KEY_OFF |-> !key_active;
  endproperty
  a_key_off: assert property (p_key_off) else $error("disabled keys active");
  property p_osc_hold;
    @(posedge clk) disable iff (sys_rst) !osc_ok |-> cpu_reset;
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("run before oscillator");
  property p_wd_pending;
    @(posedge clk) disable iff (sys_rst) ce && wd_fire |=> wd_pending;
  endproperty
  a_wd_pending: assert property (p_wd_pending) else $error("timeout lost");
  property p_clear_reads_zero;
    @(posedge clk) disable iff (sys_rst)
    avs_read && !avs_waitrequest && hit_clear |-> avs_readdata == 32'h0;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear bit read");
  property p_release_on_edge;
    @(posedge clk) disable iff (sys_rst)
    $fell(cpu_reset) |-> $past(osc_tick) && !$past(raw_reset);
  endproperty
  a_release_on_edge: assert property (p_release_on_edge) else $error("bad release");
  property p_init_loaded;
    @(posedge clk) disable iff (sys_rst)
    ce && cpu_reset |=> cpu_init.program_page_counter == INIT_PAGE
      && cpu_init.next_page_pointer == INIT_NEXT_PAGE;
  endproperty
  a_init_loaded: assert property (p_init_loaded) else $error("initial values not loaded");

endmodule

//--- rtl/rvw_pkg.sv
// Package with constants, types and register map of the initial-reset and watchdog block.
package rvw_pkg;

  // System clock and documented times in their own units.
  localparam int          CLK_PERIOD_NS     = 4;
  localparam int          PIN_FILTER_NS     = 2_000_000;
  localparam longint      KEY_HOLD_NS       = 64'd2_000_000_000;
  // Least times round up to whole clock cycles.
  localparam int          PIN_FILTER_CYCLES = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          KEY_HOLD_CYCLES   =
    int'((KEY_HOLD_NS + longint'(CLK_PERIOD_NS) - 64'd1) / longint'(CLK_PERIOD_NS));
  // Low-speed oscillator edges that prove the crystal has started.
  localparam int          OSC_START_EDGES   = 4;

  // Register indices; byte address is four times the index.
  localparam logic [11:0] REG_CLEAR_IDX     = 12'hf76;
  localparam logic [11:0] REG_KEY_CFG_IDX   = 12'hf7e;
  localparam logic [11:0] REG_STATUS_IDX    = 12'hf7f;

  // Field positions.
  localparam int          WD_CLEAR_BIT      = 0;
  localparam int          TIMER_CLEAR_BIT   = 1;
  localparam int          STAT_WD_LSB       = 0;
  localparam int          STAT_OSC_BIT      = 2;
  localparam int          STAT_KEY_LSB      = 3;

  // Key-combination choices.
  typedef enum logic [1:0] {
    RVW_KEY_OFF  = 2'h0,
    RVW_KEY_01   = 2'h1,
    RVW_KEY_012  = 2'h2,
    RVW_KEY_0123 = 2'h3
  } rvw_key_sel_e;
  localparam rvw_key_sel_e KEY_CFG_RESET    = RVW_KEY_OFF;

  // CPU values loaded during initial reset.
  typedef struct packed {
    logic [7:0] program_step_counter;
    logic [3:0] program_page_counter;
    logic       program_bank_bit;
    logic [3:0] next_page_pointer;
    logic       next_bank_pointer;
    logic       interrupt_flag;
    logic       decimal_flag;
  } rvw_cpu_init_s;

  localparam logic [7:0]  INIT_STEP         = 8'h00;
  localparam logic [3:0]  INIT_PAGE         = 4'h1;
  localparam logic        INIT_BANK         = 1'h0;
  localparam logic [3:0]  INIT_NEXT_PAGE    = 4'h1;
  localparam logic        INIT_NEXT_BANK    = 1'h0;
  localparam logic        INIT_INT_FLAG     = 1'h0;
  localparam logic        INIT_DEC_FLAG     = 1'h0;

endpackage

//--- rtl/rvw_pin_sync.sv
// Three-stage pin synchroniser bank whose output moves only when stages two and three agree.
module rvw_pin_sync
  import rvw_pkg::*;
#(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '1
)(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] agreed
);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      // Stage one feeds only stage two, so no logic sees a metastable value.
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          s1 <= INIT[g];
          s2 <= INIT[g];
          s3 <= INIT[g];
          agreed[g] <= INIT[g];
        end
        else if (ce)
        begin
          s1 <= pin[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
          begin
            agreed[g] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule

//--- rtl/rvw_watchdog.sv
// Two-bit watchdog counter of one-hertz ticks that fires when it overflows.
module rvw_watchdog
  import rvw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       cpu_reset,
  input  wire logic       tick_1hz,
  input  wire logic       clear,
  input  wire logic       advance,
  output logic            fire,
  output logic      [1:0] count
);

  logic [2:0] next_sum;

  // Tick and timer-clear advance may land together; both are counted.
  always_comb
  begin
    next_sum = {1'b0, count} + {2'b00, tick_1hz} + {2'b00, advance};
  end

  // Overflow of the two-bit count is the timeout event.
  assign fire = ce && !clear && !cpu_reset && next_sum[2];

  // Counting ignores CPU halt; a clear write restarts from zero at once.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count <= 2'h0;
    end
    else if (ce)
    begin
      if (clear || cpu_reset)
      begin
        count <= 2'h0;
      end
      else
      begin
        count <= next_sum[1:0];
      end
    end
  end

  property p_clear_zeroes;
    @(posedge clk) disable iff (sys_rst)
    ce && clear |=> count == 2'h0;
  endproperty
  a_clear_zeroes: assert property (p_clear_zeroes) else $error("watchdog clear missed");

  property p_fire_at_top;
    @(posedge clk) disable iff (sys_rst)
    fire |-> (count == 2'h3 || (count == 2'h2 && tick_1hz && advance));
  endproperty
  a_fire_at_top: assert property (p_fire_at_top) else $error("watchdog fired early");

  property p_advance_counts;
    @(posedge clk) disable iff (sys_rst)
    ce && advance && !tick_1hz && !clear && !cpu_reset && count < 2'h3
      |=> count == $past(count) + 2'h1;
  endproperty
  a_advance_counts: assert property (p_advance_counts) else $error("timer clear no count");

endmodule

//--- testbench/rvw_partner.sv
// Far-side model: low-speed crystal, clock-timer tick, reset pin and key lines.
module rvw_partner
  import rvw_pkg::*;
(
  input  wire logic       clk,
  output logic            reset_n,
  output logic      [3:0] key_input_lines,
  output logic            low_speed_oscillator,
  output logic            clock_timer_tick_1hz
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       osc_run;
  logic [1:0] div;

  // Pins idle high on their pull-ups; the crystal is still until started.
  initial
  begin
    reset_n = 1'h1;
    key_input_lines = 4'hf;
    low_speed_oscillator = 1'h0;
    clock_timer_tick_1hz = 1'h0;
    osc_run = 1'h0;
    div = 2'h0;
  end

  // A started crystal runs free, eight system cycles a period, to keep runs short.
  always @(posedge clk)
  begin
    if (osc_run)
    begin
      div <= div + 2'h1;
      if (div == 2'h3)
        low_speed_oscillator <= ~low_speed_oscillator;
    end
  end

  task automatic start_osc();
    @(posedge clk);
    osc_run <= 1'h1;
  endtask

  // The caller picks the length against the filter, short ones on purpose.
  task automatic pin_low(input int n);
    @(posedge clk);
    reset_n <= 1'h0;
    repeat (n) @(posedge clk);
    reset_n <= 1'h1;
  endtask

  task automatic keys_low(input logic [3:0] m, input int n);
    @(posedge clk);
    key_input_lines <= ~m;
    repeat (n) @(posedge clk);
    key_input_lines <= 4'hf;
  endtask

  // One-cycle tick, as the clock timer sends it.
  task automatic tick();
    @(posedge clk);
    clock_timer_tick_1hz <= 1'h1;
    @(posedge clk);
    clock_timer_tick_1hz <= 1'h0;
  endtask
endmodule

//--- testbench/test_rvw_initial_reset.sv
// Self-checking bench for the initial-reset and watchdog block.
module test_rvw_initial_reset
  import rvw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PH = 8;
  localparam int KH = 16;
  logic          clk;
  logic          sys_rst;
  logic          ce;
  logic   [13:0] avs_address;
  logic          avs_read;
  logic          avs_write;
  logic   [31:0] avs_writedata;
  logic    [3:0] avs_byteenable;
  logic   [31:0] avs_readdata;
  logic          avs_waitrequest;
  logic          reset_n;
  logic    [3:0] key_input_lines;
  logic          low_speed_oscillator;
  logic          clock_timer_tick_1hz;
  logic          clock_timer_clear;
  logic          cpu_reset;
  rvw_cpu_init_s cpu_init;
  logic   [31:0] q;
  int            errors = 0;
  int            tests_run = 0;
  int            cyc = 0;
  int            rst_cnt = 0;
  int            ctc_cnt = 0;

  rvw_initial_reset #(.PIN_HOLD(PH), .KEY_HOLD(KH), .OSC_EDGES(4)) i_rvw_initial_reset (
    .clk, .sys_rst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .reset_n, .key_input_lines,
    .low_speed_oscillator, .clock_timer_tick_1hz, .clock_timer_clear, .cpu_reset, .cpu_init);

  rvw_partner i_rvw_partner (.clk, .reset_n, .key_input_lines, .low_speed_oscillator,
    .clock_timer_tick_1hz);

  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // Counts reset and timer-clear cycles; a single writer avoids races with the tests.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cpu_reset === 1'h1)
      rst_cnt <= rst_cnt + 1;
    if (clock_timer_clear === 1'h1)
      ctc_cnt <= ctc_cnt + 1;
    if (cyc == 20000)
    begin
      errors++;
      $display("MISMATCH %0t timeout", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e, input string m);
    chk_word({31'h0, g}, {31'h0, e}, m);
  endtask

  // One Avalon transfer; the request stands until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [3:0] d);
    @(posedge clk);
    avs_address <= {idx, 2'h0};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {28'h0, d};
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic wait_rst(input logic v, input int lim);
    int n;
    n = 0;
    while (cpu_reset !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk_bit(cpu_reset, v, "cpu reset level");
  endtask

  task automatic wd_is(input logic [1:0] e);
    bus(1'h0, REG_STATUS_IDX, 4'h0);
    chk_word({30'h0, q[1:0]}, {30'h0, e}, "watchdog count");
  endtask

  // Main sequence: power-up, registers, pin filter, key choices, watchdog.
  initial
  begin
    logic [3:0] m;
    int         r0;
    sys_rst = 1'h1;
    ce = 1'h1;
    avs_address = 14'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (40) @(posedge clk);
    chk_bit(cpu_reset, 1'h1, "held while crystal still");
    chk_word({12'h0, cpu_init}, {12'h0, 8'h00, 4'h1, 1'h0, 4'h1, 3'h0}, "init values");
    i_rvw_partner.start_osc();
    i_rvw_partner.pin_low(3 * PH);
    chk_bit(cpu_reset, 1'h1, "held by pin");
    wait_rst(1'h0, 200);
    $display("Test power-up done");
    bus(1'h0, REG_CLEAR_IDX, 4'h0);
    chk_word(q, 32'h0, "clear reads zero");
    bus(1'h0, 12'h100, 4'h0);
    chk_word(q, 32'h0, "unmapped read");
    bus(1'h0, REG_STATUS_IDX, 4'h0);
    chk_bit(q[STAT_OSC_BIT], 1'h1, "crystal started");
    $display("Test registers done");
    r0 = rst_cnt;
    i_rvw_partner.pin_low(PH / 2);
    repeat (30) @(posedge clk);
    chk_word(rst_cnt - r0, 32'h0, "short pulse rejected");
    i_rvw_partner.pin_low(3 * PH);
    chk_bit(cpu_reset, 1'h1, "long pulse resets");
    wait_rst(1'h0, 200);
    $display("Test pin filter done");
    bus(1'h0, REG_KEY_CFG_IDX, 4'h0);
    chk_word(q, 32'h0, "key choice reset value");
    for (int s = 0; s < 4; s++)
    begin
      m = (s == 0) ? 4'hf : 4'hf >> (3 - s);
      bus(1'h1, REG_KEY_CFG_IDX, 4'(s));
      bus(1'h0, REG_KEY_CFG_IDX, 4'h0);
      chk_word(q, 32'(s), "key choice readback");
      r0 = rst_cnt;
      i_rvw_partner.keys_low(m >> 1, 2 * KH);
      repeat (10) @(posedge clk);
      chk_word(rst_cnt - r0, 32'h0, "partial keys");
      i_rvw_partner.keys_low(m, 2 * KH);
      chk_bit(cpu_reset, s != 0, "key reset");
      wait_rst(1'h0, 200);
    end
    bus(1'h1, REG_KEY_CFG_IDX, 4'h0);
    $display("Test keys done");
    bus(1'h1, REG_CLEAR_IDX, 4'h1);
    wd_is(2'h0);
    repeat (3) i_rvw_partner.tick();
    wd_is(2'h3);
    chk_bit(cpu_reset, 1'h0, "no fire on three ticks");
    bus(1'h1, REG_CLEAR_IDX, 4'h0);
    wd_is(2'h3);
    bus(1'h1, REG_CLEAR_IDX, 4'h1);
    wd_is(2'h0);
    i_rvw_partner.tick();
    r0 = ctc_cnt;
    bus(1'h1, REG_CLEAR_IDX, 4'h2);
    wd_is(2'h2);
    chk_word(ctc_cnt - r0, 32'h1, "timer clear pulse");
    i_rvw_partner.tick();
    i_rvw_partner.tick();
    wait_rst(1'h1, 10);
    wait_rst(1'h0, 200);
    wd_is(2'h0);
    $display("Test watchdog done");
    close_out();
  end
endmodule
